// File: common/pqa_pkg.sv
// shared constants, types and helpers of the power quality alarm monitor
package pqa_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int MS_TICK_US = 1000;
  localparam int MS_TICK_CYCLES = MS_TICK_US * 1000 / CLK_PERIOD_NS;
  localparam int SEC_MS = 1000;

  // ****************************************
  // widths and printed ranges
  // ****************************************
  localparam int REACT_W = 14;
  localparam int PF_W = 10;
  localparam int CUR_W = 13;
  localparam int PCT_W = 6;
  localparam int MPCT_W = 8;
  localparam int DLY_W = 8;
  localparam int PULSE_W = 14;
  localparam int TOPO_W = 3;
  localparam int N_GRP = 7;
  localparam int N_ALM = 8;
  localparam logic [13:0] REACT_MAX = 14'h270f;
  localparam logic [9:0] PF_MAX = 10'h3e7;
  localparam logic [12:0] CUR_MAX = 13'h1388;
  localparam logic [5:0] PCT_MAX = 6'h32;
  localparam logic [13:0] PULSE_MIN = 14'h0001;
  localparam logic [13:0] PULSE_MAX = 14'h2710;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] DLY_RESET = 8'h1e;
  localparam logic [13:0] PULSE_RESET = 14'h0064;

  // ****************************************
  // setting groups and alarm positions
  // ****************************************
  localparam int G_REACT = 0;
  localparam int G_PF = 1;
  localparam int G_CUR = 2;
  localparam int G_THDV = 3;
  localparam int G_THDI = 4;
  localparam int G_VUNB = 5;
  localparam int G_IUNB = 6;
  localparam int A_REACT = 0;
  localparam int A_PFCAP = 1;
  localparam int A_PFIND = 2;
  localparam int A_CUR = 3;
  localparam int A_THDV = 4;
  localparam int A_THDI = 5;
  localparam int A_VUNB = 6;
  localparam int A_IUNB = 7;

  typedef enum logic [2:0] {
    PQA_STAR_4W, PQA_SINGLE_2W, PQA_TWO_PH_L1L2, PQA_DELTA_3W,
    PQA_DELTA_4W, PQA_3W_2CT_L1L2, PQA_3W_2CT_L1L3, PQA_TOPO_SPARE
  } pqa_topo_e;

  typedef struct packed {
    logic [REACT_W-1:0] react_cap_lim;
    logic [REACT_W-1:0] react_ind_lim;
    logic [PF_W-1:0] pf_cap_lim;
    logic [PF_W-1:0] pf_ind_lim;
    logic [CUR_W-1:0] cur_lim;
    logic [PCT_W-1:0] thdv_lim;
    logic [PCT_W-1:0] thdi_lim;
    logic [PCT_W-1:0] vunb_lim;
    logic [PCT_W-1:0] iunb_lim;
    logic [N_GRP-1:0][DLY_W-1:0] delay;
    logic [N_GRP-1:0] lock;
    logic [PULSE_W-1:0] pulse_ms;
    pqa_topo_e topology;
  } pqa_cfg_s;

  typedef struct packed {
    logic [REACT_W-1:0] react_cap;
    logic [REACT_W-1:0] react_ind;
    logic [PF_W-1:0] pf;
    logic pf_is_cap;
    logic [CUR_W-1:0] current;
    logic [2:0][MPCT_W-1:0] voltage_harmonic_distortion;
    logic [2:0][MPCT_W-1:0] current_harmonic_distortion;
    logic [MPCT_W-1:0] v_unb;
    logic [MPCT_W-1:0] i_unb;
  } pqa_meas_s;

  localparam pqa_cfg_s CFG_RESET = '{
    react_cap_lim: '0, react_ind_lim: '0, pf_cap_lim: '0, pf_ind_lim: '0,
    cur_lim: '0, thdv_lim: '0, thdi_lim: '0, vunb_lim: '0, iunb_lim: '0,
    delay: {N_GRP{DLY_RESET}}, lock: '0, pulse_ms: PULSE_RESET,
    topology: PQA_3W_2CT_L1L2};

  // a zero limit disables the over-limit check
  function automatic logic pqa_over(input logic [13:0] v, input logic [13:0] lim);
    return (lim != 14'h0000) && (v > lim);
  endfunction

  // setting group that governs each alarm position
  function automatic int pqa_grp(input int a);
    return (a <= A_PFIND) ? ((a == A_REACT) ? G_REACT : G_PF) : a - 1;
  endfunction

endpackage

// File: logic/pqa_alarm_chan.sv
// one alarm channel: persistence delay, lock and manual reset
`timescale 1ns/1ps
module pqa_alarm_chan
  import pqa_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic sec_tick,
  input wire logic out_of_range,
  input wire logic [DLY_W-1:0] delay,
  input wire logic lock,
  input wire logic hold_mode,
  input wire logic manual_reset,
  output logic alarm_reg
);

  logic [DLY_W-1:0] count_reg;
  logic reached;
  logic clear_ok;

  assign reached = (count_reg >= delay);
  // hold mode times the hold-off after recovery instead of the onset
  assign clear_ok = lock ? manual_reset : (!hold_mode || reached);

  // ****************************************
  // seconds counter
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else if (hold_mode ? out_of_range : !out_of_range) begin
      count_reg <= '0;
    end else if (sec_tick && !reached) begin
      count_reg <= count_reg + 8'h01;
    end
  end

  // ****************************************
  // alarm flag
  // ****************************************
  // an out-of-range cycle always wins over a clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_reg <= 1'b0;
    end else if (out_of_range && (hold_mode || reached)) begin
      alarm_reg <= 1'b1;
    end else if (alarm_reg && !out_of_range && clear_ok) begin
      alarm_reg <= 1'b0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_auto_clear;
    alarm_reg && !out_of_range && !lock && !hold_mode;
  endsequence

  sequence s_hold_wait;
    hold_mode && !lock && alarm_reg && !out_of_range && !reached;
  endsequence

  a_set_needs_out: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(alarm_reg) |-> $past(out_of_range)) else $error("alarm rose without cause");
  a_zero_delay_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!hold_mode && out_of_range && delay == 8'h00) |=> alarm_reg) else $error("zero delay not immediate");
  a_auto_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_auto_clear |=> !alarm_reg) else $error("self-clearing alarm stuck");
  a_latch_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (lock && alarm_reg && !manual_reset) |=> alarm_reg) else $error("latched alarm dropped");
  a_reset_keeps_out: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (alarm_reg && out_of_range) |=> alarm_reg) else $error("alarm cleared while out of range");
  a_count_restart: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!hold_mode && !out_of_range) |=> count_reg == 8'h00) else $error("delay count not restarted");
  a_hold_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_hold_wait |=> alarm_reg) else $error("hold-off ended early");
  a_no_early_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!hold_mode && !alarm_reg && count_reg < delay && !(sec_tick && out_of_range)) |=> !alarm_reg)
    else $error("alarm set before delay");

endmodule

// File: logic/pqa_pulse_stretch.sv
// energy pulse stretcher counting in millisecond ticks
`timescale 1ns/1ps
module pqa_pulse_stretch
  import pqa_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ms_tick,
  input wire logic trigger,
  input wire logic [PULSE_W-1:0] len_ms,
  output logic pulse_reg
);

  logic [PULSE_W-1:0] left_reg;

  // a new trigger restarts the full length
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_reg <= 1'b0;
      left_reg <= '0;
    end else if (trigger) begin
      pulse_reg <= 1'b1;
      left_reg <= len_ms;
    end else if (pulse_reg && ms_tick) begin
      if (left_reg <= PULSE_MIN) begin
        pulse_reg <= 1'b0;
        left_reg <= '0;
      end else begin
        left_reg <= left_reg - PULSE_MIN;
      end
    end
  end

  a_pulse_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
    trigger |=> pulse_reg && left_reg == $past(len_ms)) else $error("pulse not started");
  a_pulse_steady: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (pulse_reg && !ms_tick && !trigger) |=> pulse_reg && $stable(left_reg)) else $error("pulse cut short");

endmodule

// File: logic/pqa_top.sv
// power quality alarm monitor: limits, persistence, latching, pulses
`timescale 1ns/1ps
module pqa_top
  import pqa_pkg::*;
#(
  parameter int MS_CYCLES = MS_TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire pqa_cfg_s cfg_in,
  input wire logic cfg_load,
  input wire pqa_meas_s meas,
  input wire logic manual_reset,
  input wire logic active_energy_tick,
  input wire logic reactive_energy_tick,
  output logic [N_ALM-1:0] alarm,
  output logic any_alarm_reg,
  output logic cfg_error_reg,
  output pqa_topo_e topology_code,
  output logic active_pulse,
  output logic reactive_pulse
);

  // ****************************************
  // reset release
  // ****************************************
  logic [1:0] rst_sync_reg;
  logic rst_sync_n;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_sync_n = rst_sync_reg[1];

  // ****************************************
  // millisecond and second enables
  // ****************************************
  logic [15:0] ms_div_reg;
  logic [9:0] sec_div_reg;
  logic ms_tick_reg;
  logic sec_tick_reg;

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ms_div_reg <= '0;
      ms_tick_reg <= 1'b0;
    end else if (ms_div_reg == 16'(MS_CYCLES - 1)) begin
      ms_div_reg <= '0;
      ms_tick_reg <= 1'b1;
    end else begin
      ms_div_reg <= ms_div_reg + 16'h0001;
      ms_tick_reg <= 1'b0;
    end
  end

  // the second is built from milliseconds so one divider sets both rates
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sec_div_reg <= '0;
      sec_tick_reg <= 1'b0;
    end else if (ms_tick_reg && sec_div_reg == 10'(SEC_MS - 1)) begin
      sec_div_reg <= '0;
      sec_tick_reg <= 1'b1;
    end else begin
      if (ms_tick_reg) begin
        sec_div_reg <= sec_div_reg + 10'h001;
      end
      sec_tick_reg <= 1'b0;
    end
  end

  // ****************************************
  // settings
  // ****************************************
  pqa_cfg_s cfg_reg;
  logic cfg_bad;

  // a load with any field outside its range is refused whole
  always_comb begin
    cfg_bad = 1'b0;
    if (cfg_in.react_cap_lim > REACT_MAX || cfg_in.react_ind_lim > REACT_MAX) begin
      cfg_bad = 1'b1;
    end
    if (cfg_in.pf_cap_lim > PF_MAX || cfg_in.pf_ind_lim > PF_MAX) begin
      cfg_bad = 1'b1;
    end
    if (cfg_in.cur_lim > CUR_MAX) begin
      cfg_bad = 1'b1;
    end
    if (cfg_in.thdv_lim > PCT_MAX || cfg_in.thdi_lim > PCT_MAX) begin
      cfg_bad = 1'b1;
    end
    if (cfg_in.vunb_lim > PCT_MAX || cfg_in.iunb_lim > PCT_MAX) begin
      cfg_bad = 1'b1;
    end
    if (cfg_in.pulse_ms < PULSE_MIN || cfg_in.pulse_ms > PULSE_MAX) begin
      cfg_bad = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cfg_reg <= CFG_RESET;
    end else if (cfg_load && !cfg_bad) begin
      cfg_reg <= cfg_in;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cfg_error_reg <= 1'b0;
    end else if (cfg_load) begin
      cfg_error_reg <= cfg_bad;
    end
  end

  assign topology_code = cfg_reg.topology;

  // ****************************************
  // limit comparison
  // ****************************************
  logic [N_ALM-1:0] out_next;
  logic [N_ALM-1:0] out_reg;
  logic thdv_any;
  logic thdi_any;

  always_comb begin
    thdv_any = 1'b0;
    thdi_any = 1'b0;
    for (int ch = 0; ch < 3; ch++) begin
      if (pqa_over({6'h00, meas.voltage_harmonic_distortion[ch]}, {8'h00, cfg_reg.thdv_lim})) begin
        thdv_any = 1'b1;
      end
      if (pqa_over({6'h00, meas.current_harmonic_distortion[ch]}, {8'h00, cfg_reg.thdi_lim})) begin
        thdi_any = 1'b1;
      end
    end
  end

  always_comb begin
    out_next = '0;
    out_next[A_REACT] = pqa_over(meas.react_cap, cfg_reg.react_cap_lim) ||
                        pqa_over(meas.react_ind, cfg_reg.react_ind_lim);
    out_next[A_PFCAP] = meas.pf_is_cap && (meas.pf < cfg_reg.pf_cap_lim);
    out_next[A_PFIND] = !meas.pf_is_cap && (meas.pf < cfg_reg.pf_ind_lim);
    out_next[A_CUR] = pqa_over({1'b0, meas.current}, {1'b0, cfg_reg.cur_lim});
    out_next[A_THDV] = thdv_any;
    out_next[A_THDI] = thdi_any;
    out_next[A_VUNB] = pqa_over({6'h00, meas.v_unb}, {8'h00, cfg_reg.vunb_lim});
    out_next[A_IUNB] = pqa_over({6'h00, meas.i_unb}, {8'h00, cfg_reg.iunb_lim});
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      out_reg <= '0;
    end else begin
      out_reg <= out_next;
    end
  end

  // ****************************************
  // alarm channels
  // ****************************************
  // the two power factor alarms share one delay and one lock
  generate
    for (genvar a = 0; a < N_ALM; a++) begin : g_chan
      pqa_alarm_chan u_chan (
        .ref_clk(ref_clk),
        .rst_n(rst_sync_n),
        .sec_tick(sec_tick_reg),
        .out_of_range(out_reg[a]),
        .delay(cfg_reg.delay[pqa_grp(a)]),
        .lock(cfg_reg.lock[pqa_grp(a)]),
        .hold_mode(a == A_IUNB),
        .manual_reset(manual_reset),
        .alarm_reg(alarm[a])
      );
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      any_alarm_reg <= 1'b0;
    end else begin
      any_alarm_reg <= |alarm;
    end
  end

  // ****************************************
  // energy pulses
  // ****************************************
  // length resolution is one millisecond; the first tick may come early
  pqa_pulse_stretch u_active (
    .ref_clk(ref_clk),
    .rst_n(rst_sync_n),
    .ms_tick(ms_tick_reg),
    .trigger(active_energy_tick),
    .len_ms(cfg_reg.pulse_ms),
    .pulse_reg(active_pulse)
  );

  pqa_pulse_stretch u_reactive (
    .ref_clk(ref_clk),
    .rst_n(rst_sync_n),
    .ms_tick(ms_tick_reg),
    .trigger(reactive_energy_tick),
    .len_ms(cfg_reg.pulse_ms),
    .pulse_reg(reactive_pulse)
  );

  // ****************************************
  // checks
  // ****************************************
  a_topo_load: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (cfg_load && !cfg_bad) |=> topology_code == $past(cfg_in.topology)) else $error("topology not loaded");
  a_bad_refused: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (cfg_load && cfg_bad) |=> $stable(cfg_reg) && cfg_error_reg) else $error("bad settings taken");
  a_react_cause: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (meas.react_cap > cfg_reg.react_cap_lim && cfg_reg.react_cap_lim != 14'h0000 && !cfg_load)
    |=> out_reg[A_REACT]) else $error("reactive excess missed");
  a_sec_single: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    sec_tick_reg |=> !sec_tick_reg) else $error("second tick too long");

endmodule

// File: tb/pqa_top_test.sv
// self-checking testbench of the power quality alarm monitor
`timescale 1ns/1ps
module pqa_top_test;
  import pqa_pkg::*;

  // ****************************************
  // design hookup
  // ****************************************
  localparam int MSC = 10;
  localparam int SEC = MSC * SEC_MS;
  logic ref_clk;
  logic rst_n;
  pqa_cfg_s cfg_in;
  logic cfg_load;
  pqa_meas_s meas;
  logic manual_reset;
  logic active_energy_tick;
  logic reactive_energy_tick;
  logic [N_ALM-1:0] alarm;
  logic any_alarm_reg;
  logic cfg_error_reg;
  pqa_topo_e topology_code;
  logic active_pulse;
  logic reactive_pulse;
  int errors;
  int samples_checked;
  pqa_cfg_s c;
  pqa_meas_s row_in[10];
  logic [7:0] row_exp[10];

  pqa_top #(.MS_CYCLES(MSC)) i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .cfg_in(cfg_in), .cfg_load(cfg_load), .meas(meas),
    .manual_reset(manual_reset), .active_energy_tick(active_energy_tick),
    .reactive_energy_tick(reactive_energy_tick), .alarm(alarm), .any_alarm_reg(any_alarm_reg),
    .cfg_error_reg(cfg_error_reg), .topology_code(topology_code), .active_pulse(active_pulse),
    .reactive_pulse(reactive_pulse)
  );

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_test(input string name);
    $display("test %s finished, mismatches so far %0d", name, errors);
  endtask

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic load(input pqa_cfg_s v);
    cfg_in = v;
    cfg_load = 1'b1;
    cyc(1);
    cfg_load = 1'b0;
    cyc(1);
  endtask

  task automatic strobe_reset();
    manual_reset = 1'b1;
    cyc(1);
    manual_reset = 1'b0;
    cyc(2);
  endtask

  // quantities well inside every limit used below; 11 raises every alarm but the inductive power factor one
  function automatic pqa_meas_s row_meas(input int i);
    pqa_meas_s m;
    m = '0;
    m.pf = 10'h3e7;
    m.pf_is_cap = 1'b1;
    if (i == 1 || i == 11) m.react_cap = 14'h07d0;
    if (i == 2) m.react_ind = 14'h07d0;
    if (i == 3 || i == 11) m.pf = 10'h064;
    if (i == 4) begin
      m.pf = 10'h064;
      m.pf_is_cap = 1'b0;
    end
    if (i == 5 || i == 11) m.current = 13'h00c8;
    if (i == 6 || i == 11) m.voltage_harmonic_distortion[2] = 8'h14;
    if (i == 7 || i == 11) m.current_harmonic_distortion[1] = 8'h14;
    if (i == 8 || i == 11) m.v_unb = 8'h14;
    if (i == 9 || i == 11) m.i_unb = 8'h14;
    return m;
  endfunction

  function automatic pqa_cfg_s work_cfg();
    pqa_cfg_s v;
    v = CFG_RESET;
    v.react_cap_lim = 14'h03e8;
    v.react_ind_lim = 14'h03e8;
    v.pf_cap_lim = 10'h1f4;
    v.pf_ind_lim = 10'h1f4;
    v.cur_lim = 13'h0064;
    v.thdv_lim = 6'h0a;
    v.thdi_lim = 6'h0a;
    v.vunb_lim = 6'h0a;
    v.iunb_lim = 6'h0a;
    v.delay = '0;
    v.pulse_ms = 14'h0003;
    return v;
  endfunction

  // hang guard: the whole run takes just over half this bound
  initial begin
    repeat (100000) @(posedge ref_clk);
    errors++;
    $display("run exceeded its cycle bound");
    stop_test();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    errors = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    cfg_in = CFG_RESET;
    cfg_load = 1'b0;
    meas = row_meas(0);
    manual_reset = 1'b0;
    active_energy_tick = 1'b0;
    reactive_energy_tick = 1'b0;
    row_exp = '{8'h00, 8'h01, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};
    for (int i = 0; i < 10; i++) row_in[i] = row_meas(i);
    cyc(2);
    check({8'h00, alarm}, 16'h0000);
    check({13'h0000, topology_code}, 16'h0005);
    rst_n = 1'b1;
    cyc(3);
    check({15'h0000, cfg_error_reg}, 16'h0000);
    end_test("reset");

    // factory pulse length is 100 ms
    active_energy_tick = 1'b1;
    cyc(1);
    active_energy_tick = 1'b0;
    check({15'h0000, active_pulse}, 16'h0001);
    cyc(98 * MSC);
    check({15'h0000, active_pulse}, 16'h0001);
    cyc(3 * MSC);
    check({15'h0000, active_pulse}, 16'h0000);
    end_test("default pulse");

    // every topology code at boundary limits, then refused loads
    c = CFG_RESET;
    c.react_cap_lim = REACT_MAX;
    c.pf_ind_lim = PF_MAX;
    c.cur_lim = CUR_MAX;
    c.iunb_lim = PCT_MAX;
    c.pulse_ms = PULSE_MAX;
    for (int t = 0; t < 8; t++) begin
      c.topology = pqa_topo_e'(t[2:0]);
      load(c);
      check({15'h0000, cfg_error_reg}, 16'h0000);
      check({13'h0000, topology_code}, t[15:0]);
    end
    for (int k = 0; k < 4; k++) begin
      c = CFG_RESET;
      c.topology = PQA_TWO_PH_L1L2;
      if (k == 0) c.thdv_lim = 6'h33;
      if (k == 1) c.pulse_ms = 14'h0000;
      if (k == 2) c.pulse_ms = 14'h2711;
      if (k == 3) c.cur_lim = 13'h1389;
      load(c);
      check({15'h0000, cfg_error_reg}, 16'h0001);
      check({13'h0000, topology_code}, 16'h0007);
    end
    end_test("settings");

    // one quantity at a time, no delay, self-clearing
    c = work_cfg();
    c.delay[G_IUNB] = 8'h02;
    load(c);
    for (int i = 0; i < 10; i++) begin
      meas = row_in[i];
      cyc(3);
      check({8'h00, alarm}, {8'h00, row_exp[i]});
    end
    check({15'h0000, any_alarm_reg}, 16'h0001);
    end_test("limits");

    // current unbalance lingers the programmed 2 s after recovery
    meas = row_meas(0);
    cyc(SEC - 10);
    check({8'h00, alarm}, 16'h0080);
    cyc(SEC + 20);
    check({8'h00, alarm}, 16'h0000);
    end_test("unbalance hold-off");

    // retriggered reactive pulse of 3 ms
    reactive_energy_tick = 1'b1;
    cyc(1);
    reactive_energy_tick = 1'b0;
    cyc(14);
    reactive_energy_tick = 1'b1;
    cyc(1);
    reactive_energy_tick = 1'b0;
    cyc(18);
    check({15'h0000, reactive_pulse}, 16'h0001);
    cyc(17);
    check({15'h0000, reactive_pulse}, 16'h0000);
    end_test("pulse retrigger");

    // 2 s persistence on high current, restarted by a short recovery
    c = work_cfg();
    c.delay[G_CUR] = 8'h02;
    load(c);
    meas = row_in[5];
    // the first second tick may fall anywhere in the first second, so only under one second is safe
    cyc(SEC - 10);
    check({8'h00, alarm}, 16'h0000);
    meas = row_meas(0);
    cyc(5);
    meas = row_in[5];
    cyc(SEC - 10);
    check({8'h00, alarm}, 16'h0000);
    cyc(SEC + 20);
    check({8'h00, alarm}, 16'h0008);
    meas = row_meas(0);
    cyc(3);
    check({8'h00, alarm}, 16'h0000);
    end_test("persistence");

    // latched alarms and the manual reset strobe
    c = work_cfg();
    c.lock = 7'h7f;
    load(c);
    meas = row_meas(11);
    cyc(3);
    check({8'h00, alarm}, 16'h00fb);
    meas = row_in[1];
    cyc(3);
    check({8'h00, alarm}, 16'h00fb);
    strobe_reset();
    check({8'h00, alarm}, 16'h0001);
    meas = row_meas(0);
    cyc(3);
    check({8'h00, alarm}, 16'h0001);
    strobe_reset();
    check({8'h00, alarm}, 16'h0000);
    cyc(1);
    check({15'h0000, any_alarm_reg}, 16'h0000);
    end_test("latching");
    stop_test();
  end
endmodule
